// ==== src/sti_biphase_div.sv ====
// divider from the sampled oversampling clock to the biphase clock tick
module sti_biphase_div
    import sti_pkg::*;
(
    input  wire logic       i_clk,      // system clock
    input  wire logic       i_rst_n,    // synchronised reset, active low
    input  wire logic       i_ce,       // clock enable
    input  wire logic       i_osc,      // oversample_clock level
    input  wire logic [1:0] i_ratio,    // ratio code
    output logic            o_tick      // one-cycle biphase tick
);

    logic       osc_prev_r;
    logic       osc_prev_nxt;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic       tick_r;
    logic       tick_nxt;
    logic [2:0] div;

    always_comb begin
        case (i_ratio)
            STI_RATIO_384: div = STI_DIV_384;
            STI_RATIO_512: div = STI_DIV_512;
            STI_RATIO_768: div = STI_DIV_768;
            default:       div = STI_DIV_256;
        endcase
        osc_prev_nxt = i_osc;
        cnt_nxt      = cnt_r;
        tick_nxt     = 1'b0;
        if (i_osc && !osc_prev_r) begin
            if (cnt_r >= div - 3'h1) begin
                cnt_nxt  = '0;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 3'h1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            osc_prev_r <= 1'b0;
            cnt_r      <= '0;
            tick_r     <= 1'b0;
        end else if (i_ce) begin
            osc_prev_r <= osc_prev_nxt;
            cnt_r      <= cnt_nxt;
            tick_r     <= tick_nxt;
        end
    end

    assign o_tick = tick_r;

endmodule

// ==== src/sti_pkg.sv ====
// shared constants and carrier types for the serial audio input stage
package sti_pkg;

    // ======================================================================
    // framing modes (i2s is the reset default)
    // ======================================================================
    localparam logic [1:0] STI_MODE_I2S = 2'h0;
    localparam logic [1:0] STI_MODE_LJ  = 2'h1;
    localparam logic [1:0] STI_MODE_RJ  = 2'h2;

    // ======================================================================
    // sample word width codes and their bit counts
    // ======================================================================
    localparam logic [1:0] STI_WID_16 = 2'h0;
    localparam logic [1:0] STI_WID_18 = 2'h1;
    localparam logic [1:0] STI_WID_20 = 2'h2;
    localparam logic [1:0] STI_WID_24 = 2'h3;
    localparam logic [4:0] STI_BITS_16 = 5'h10;
    localparam logic [4:0] STI_BITS_18 = 5'h12;
    localparam logic [4:0] STI_BITS_20 = 5'h14;
    localparam logic [4:0] STI_BITS_24 = 5'h18;
    localparam int         STI_SAMPLE_W = 24;
    localparam logic [23:0] STI_ALL_ONES = 24'hffffff;

    // ======================================================================
    // oversampling ratio codes and divide factors to the biphase clock
    // biphase cell rate is 128 x frame rate
    // ======================================================================
    localparam logic [1:0] STI_RATIO_256 = 2'h0;
    localparam logic [1:0] STI_RATIO_384 = 2'h1;
    localparam logic [1:0] STI_RATIO_512 = 2'h2;
    localparam logic [1:0] STI_RATIO_768 = 2'h3;
    localparam logic [2:0] STI_DIV_256 = 3'h2;
    localparam logic [2:0] STI_DIV_384 = 3'h3;
    localparam logic [2:0] STI_DIV_512 = 3'h4;
    localparam logic [2:0] STI_DIV_768 = 3'h6;

    // ======================================================================
    // bit counter
    // ======================================================================
    localparam logic [7:0] STI_CNT_MAX = 8'hff;

    // ======================================================================
    // carriers
    // ======================================================================
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] width;
        logic [1:0] ratio;
    } sti_cfg_t;

    localparam sti_cfg_t STI_CFG_RST = '{mode: STI_MODE_I2S, width: STI_WID_24,
                                         ratio: STI_RATIO_256};

    typedef struct packed {
        logic [23:0] left;
        logic [23:0] right;
    } sti_pair_t;

endpackage

// ==== src/sti_serial_in.sv ====
// serial audio input stage of the s/pdif transmitter
module sti_serial_in
    import sti_pkg::*;
(
    input  wire logic       i_clk,              // system clock, 100 MHz
    input  wire logic       i_arst_n,           // async reset, active low
    input  wire logic       i_ce,               // clock enable, freezes all state except the reset synchroniser
    input  wire logic       i_cfg_wr,           // load configuration strobe
    input  wire sti_cfg_t   i_cfg,              // mode, width, ratio
    input  wire logic       i_bit_clk,          // serial bit clock level
    input  wire logic       i_frame_sync,       // left/right frame clock
    input  wire logic       i_serial_sample_in, // serial data
    input  wire logic       i_oversample_clock, // oversampling clock level
    output sti_cfg_t        o_cfg,              // configuration in force
    output sti_pair_t       o_pair,             // last completed sample pair
    output logic            o_pair_valid,       // one-cycle pulse with o_pair
    output logic            o_biphase_tick      // one-cycle biphase clock tick
);

    // ======================================================================
    // reset release
    // ======================================================================
    logic       rst_s1_r;
    logic       rst_n_r;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // ======================================================================
    // configuration
    // ======================================================================
    sti_cfg_t   cfg_r;
    sti_cfg_t   cfg_nxt;

    always_comb begin
        cfg_nxt = cfg_r;
        if (i_cfg_wr) begin
            cfg_nxt = i_cfg;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cfg_r <= STI_CFG_RST;
        end else if (i_ce) begin
            cfg_r <= cfg_nxt;
        end
    end

    // ======================================================================
    // word width decode
    // ======================================================================
    logic [4:0]  nbits;
    logic [23:0] mask;
    logic [4:0]  pad;

    always_comb begin
        case (cfg_r.width)
            STI_WID_16: nbits = STI_BITS_16;
            STI_WID_18: nbits = STI_BITS_18;
            STI_WID_20: nbits = STI_BITS_20;
            default:    nbits = STI_BITS_24;
        endcase
        pad  = STI_BITS_24 - nbits;
        mask = STI_ALL_ONES >> pad;
    end

    // ======================================================================
    // serial capture
    // ======================================================================
    logic        bclk_prev_r;
    logic        bclk_prev_nxt;
    logic        fs_prev_r;
    logic        fs_prev_nxt;
    logic        seen_r;
    logic        seen_nxt;
    logic        armed_r;
    logic        armed_nxt;
    logic [7:0]  cnt_r;
    logic [7:0]  cnt_nxt;
    logic [23:0] sh_r;
    logic [23:0] sh_nxt;
    logic [23:0] left_r;
    logic [23:0] left_nxt;
    logic        left_ok_r;
    logic        left_ok_nxt;
    sti_pair_t   pair_r;
    sti_pair_t   pair_nxt;
    logic        valid_r;
    logic        valid_nxt;
    logic        rise;
    logic        fs_edge;
    logic        old_left;
    logic        take;
    logic [7:0]  cnt_inc;
    logic [23:0] word;

    always_comb begin
        bclk_prev_nxt = i_bit_clk;
        fs_prev_nxt   = fs_prev_r;
        seen_nxt      = seen_r;
        armed_nxt     = armed_r;
        cnt_nxt       = cnt_r;
        sh_nxt        = sh_r;
        left_nxt      = left_r;
        left_ok_nxt   = left_ok_r;
        pair_nxt      = pair_r;
        valid_nxt     = 1'b0;
        rise          = i_bit_clk && !bclk_prev_r;
        // the first rise after reset learns the frame_sync level but flags no edge, so a
        // reset value unlike the idle line cannot fake a channel boundary
        fs_edge       = rise && armed_r && (i_frame_sync != fs_prev_r);
        // channel that just ended; i2s has the opposite polarity
        if (cfg_r.mode == STI_MODE_I2S) begin
            old_left = !fs_prev_r;
        end else begin
            old_left = fs_prev_r;
        end
        // word is msb-aligned in the 24-bit field, low bits zero
        word    = (sh_r & mask) << pad;
        cnt_inc = (cnt_r == STI_CNT_MAX) ? cnt_r : cnt_r + 8'h01;
        // left/i2s keep a fixed window; right-justified shifts the whole
        // channel so the last bits before the transition are the word
        case (cfg_r.mode)
            STI_MODE_LJ: take = (cnt_inc < {3'h0, nbits});
            STI_MODE_RJ: take = 1'b1;
            default:     take = (cnt_inc >= 8'h01) &&
                                (cnt_inc <= {3'h0, nbits});
        endcase
        if (rise) begin
            fs_prev_nxt = i_frame_sync;
            armed_nxt   = 1'b1;
            if (fs_edge) begin
                cnt_nxt  = '0;
                seen_nxt = 1'b1;
                // first channel after reset is partial, so it is dropped
                if (seen_r) begin
                    if (old_left) begin
                        left_nxt    = word;
                        left_ok_nxt = 1'b1;
                    end else if (left_ok_r) begin
                        pair_nxt    = '{left: left_r, right: word};
                        valid_nxt   = 1'b1;
                        left_ok_nxt = 1'b0;
                    end
                end
                if (cfg_r.mode == STI_MODE_I2S) begin
                    sh_nxt = '0;
                end else begin
                    sh_nxt = {23'h0, i_serial_sample_in};
                end
            end else begin
                cnt_nxt = cnt_inc;
                if (take) begin
                    sh_nxt = {sh_r[22:0], i_serial_sample_in};
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            bclk_prev_r <= 1'b0;
            fs_prev_r   <= 1'b0;
            seen_r      <= 1'b0;
            armed_r     <= 1'b0;
            cnt_r       <= '0;
            sh_r        <= '0;
            left_r      <= '0;
            left_ok_r   <= 1'b0;
            pair_r      <= '0;
            valid_r     <= 1'b0;
        end else if (i_ce) begin
            bclk_prev_r <= bclk_prev_nxt;
            fs_prev_r   <= fs_prev_nxt;
            seen_r      <= seen_nxt;
            armed_r     <= armed_nxt;
            cnt_r       <= cnt_nxt;
            sh_r        <= sh_nxt;
            left_r      <= left_nxt;
            left_ok_r   <= left_ok_nxt;
            pair_r      <= pair_nxt;
            valid_r     <= valid_nxt;
        end
    end

    // ======================================================================
    // biphase clock divider
    // ======================================================================
    // limitation: the oversample clock is sampled by i_clk, so it must stay
    // below half the system clock rate
    logic tick;

    sti_biphase_div u_div (
        .i_clk   (i_clk),
        .i_rst_n (rst_n_r),
        .i_ce    (i_ce),
        .i_osc   (i_oversample_clock),
        .i_ratio (cfg_r.ratio),
        .o_tick  (tick)
    );

    // ======================================================================
    // outputs
    // ======================================================================
    assign o_cfg          = cfg_r;
    assign o_pair         = pair_r;
    assign o_pair_valid   = valid_r;
    assign o_biphase_tick = tick;

endmodule

// ==== tb/sti_serial_in_asserts.sv ====
// port checker for the serial audio input stage
module sti_serial_in_asserts
    import sti_pkg::*;
(
    input  wire logic      i_clk,              // clock
    input  wire logic      i_arst_n,           // reset
    input  wire logic      i_ce,               // enable
    input  wire logic      i_cfg_wr,           // cfg strobe
    input  wire sti_cfg_t  i_cfg,              // cfg in
    input  wire logic      i_bit_clk,          // bit clock
    input  wire logic      i_frame_sync,       // frame sync
    input  wire logic      i_serial_sample_in, // data
    input  wire logic      i_oversample_clock, // oversample
    input  wire sti_cfg_t  o_cfg,              // cfg out
    input  wire sti_pair_t o_pair,             // pair
    input  wire logic      o_pair_valid,       // pair strobe
    input  wire logic      o_biphase_tick      // tick
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // properties
    // ======================================================================
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    logic lft;
    assign lft = (o_cfg.mode == STI_MODE_LJ) || (o_cfg.mode == STI_MODE_RJ);
    // one or two cycles of latency accepted behind the input sampling
    sequence s_bclk_rose;
        ($past(i_bit_clk) && !$past(i_bit_clk, 2)) ||
        ($past(i_bit_clk, 2) && !$past(i_bit_clk, 3));
    endsequence
    sequence s_osc_rose;
        ($past(i_oversample_clock) && !$past(i_oversample_clock, 2)) ||
        ($past(i_oversample_clock, 2) && !$past(i_oversample_clock, 3));
    endsequence
    property p_valid_pulse; o_pair_valid |=> !o_pair_valid; endproperty
    property p_pair_hold; !o_pair_valid |-> $stable(o_pair); endproperty
    property p_valid_rise; o_pair_valid |-> s_bclk_rose; endproperty
    property p_valid_left; o_pair_valid |-> i_frame_sync == lft; endproperty
    property p_cfg_load; i_cfg_wr && i_ce |=> o_cfg == $past(i_cfg); endproperty
    property p_cfg_hold; !(i_cfg_wr && i_ce) |=> $stable(o_cfg); endproperty
    property p_rst_cfg; $rose(i_arst_n) |-> o_cfg == STI_CFG_RST; endproperty
    property p_tick_gap; o_biphase_tick |=> !o_biphase_tick [*3]; endproperty
    property p_tick_cause; o_biphase_tick |-> s_osc_rose; endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("pair strobe longer than one cycle");
    a_pair_hold: assert property (p_pair_hold)
        else $error("pair changed without strobe");
    a_valid_rise: assert property (p_valid_rise)
        else $error("pair strobe not after bit clock rise");
    a_valid_left: assert property (p_valid_left)
        else $error("pair strobe outside left channel level");
    a_cfg_load: assert property (p_cfg_load)
        else $error("cfg not loaded");
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("cfg changed without strobe");
    a_rst_cfg: assert property (p_rst_cfg)
        else $error("cfg not default after reset");
    a_tick_gap: assert property (p_tick_gap)
        else $error("ticks too close");
    a_tick_cause: assert property (p_tick_cause)
        else $error("tick without oversample rise");
endmodule

bind sti_serial_in sti_serial_in_asserts u_chk (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_cfg_wr(i_cfg_wr),
    .i_cfg(i_cfg), .i_bit_clk(i_bit_clk), .i_frame_sync(i_frame_sync),
    .i_serial_sample_in(i_serial_sample_in), .i_oversample_clock(i_oversample_clock),
    .o_cfg(o_cfg), .o_pair(o_pair), .o_pair_valid(o_pair_valid),
    .o_biphase_tick(o_biphase_tick));

// ==== tb/sti_serial_in_tb.sv ====
// self-checking bench for the serial audio input stage
module sti_serial_in_tb
    import sti_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        arst_n;
    logic        cfg_wr;
    logic        ce;
    logic        osc;
    logic        bclk;
    logic        fs;
    logic        sd;
    logic        pv;
    logic        tick;
    logic [1:0]  osc_cnt;
    sti_cfg_t    cfg;
    sti_cfg_t    cfg_o;
    sti_pair_t   pair;
    sti_pair_t   got;
    int          bad_count;
    int          n_tests;
    int          cyc;
    int          n_pairs;
    int          wbits [4] = '{16, 18, 20, 24};
    localparam logic [23:0] SL = 24'hc35a96;
    localparam logic [23:0] SR = 24'h6b1e2d;

    sti_src_model src (.i_clk(clk), .o_bclk(bclk), .o_fs(fs), .o_sd(sd));
    sti_serial_in dut (
        .i_clk(clk), .i_arst_n(arst_n), .i_ce(ce), .i_cfg_wr(cfg_wr), .i_cfg(cfg),
        .i_bit_clk(bclk), .i_frame_sync(fs), .i_serial_sample_in(sd),
        .i_oversample_clock(osc), .o_cfg(cfg_o), .o_pair(pair),
        .o_pair_valid(pv), .o_biphase_tick(tick));

    // ======================================================================
    // clock, oversample clock, capture, timeout
    // ======================================================================
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        osc_cnt <= osc_cnt + 2'h1;
        osc     <= osc_cnt[1];
        cyc     <= cyc + 1;
        if (pv === 1'b1) begin
            got     <= pair;
            n_pairs <= n_pairs + 1;
        end
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            summarize();
        end
    end

    // ======================================================================
    // helpers
    // ======================================================================
    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] act);
        n_tests++;
        if (act !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, act);
        end
    endtask
    task automatic set_cfg(input logic [1:0] m, input logic [1:0] w, input logic [1:0] r);
        @(posedge clk);
        cfg    <= '{mode: m, width: w, ratio: r};
        cfg_wr <= 1'b1;
        @(posedge clk);
        cfg_wr <= 1'b0;
        @(posedge clk);
        check("cfg", 48'(cfg), 48'(cfg_o));
    endtask
    // decoy frame first: its pair must not be the one left standing
    task automatic run_pair(input logic [1:0] m, input logic [1:0] wc, input int bits,
                            input logic do_cfg);
        sti_pair_t e;
        int c;
        if (do_cfg) set_cfg(m, wc, STI_RATIO_256);
        src.send_frame(m, bits, ~SL, ~SR);
        src.send_frame(m, bits, SL, SR);
        c = n_pairs;
        src.send_frame(m, bits, 24'h0, 24'h0);
        e.left  = SL << (24 - bits);
        e.right = SR << (24 - bits);
        check("pair", e, got);
        check("pair count", 48'h1, 48'(n_pairs - c));
    endtask
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tick !== 1'b1 && n < 100);
    endtask

    // ======================================================================
    // scenarios
    // ======================================================================
    task automatic t_default;
        check("reset cfg", 48'(STI_CFG_RST), 48'(cfg_o));
        run_pair(STI_MODE_I2S, STI_WID_24, 24, 1'b0);
    endtask
    task automatic t_i2s;
        for (int i = 0; i < 4; i++) begin
            run_pair(STI_MODE_I2S, 2'(i), wbits[i], 1'b1);
        end
    endtask
    task automatic t_lj;
        for (int i = 0; i < 4; i++) begin
            run_pair(STI_MODE_LJ, 2'(i), wbits[i], 1'b1);
        end
    endtask
    task automatic t_rj;
        for (int i = 0; i < 4; i++) begin
            run_pair(STI_MODE_RJ, 2'(i), wbits[i], 1'b1);
        end
    endtask
    // second reset in mid-run: defaults return and capture starts over
    task automatic t_reset;
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check("re-reset cfg", 48'(STI_CFG_RST), 48'(cfg_o));
        check("re-reset pair", 48'h0, 48'(pair));
        run_pair(STI_MODE_I2S, STI_WID_24, 24, 1'b0);
    endtask
    task automatic t_divider;
        int rat [4] = '{256, 384, 512, 768};
        int gap;
        for (int r = 0; r < 4; r++) begin
            set_cfg(STI_MODE_I2S, STI_WID_24, 2'(r));
            repeat (3) wait_tick(gap);
            check("tick gap", 48'(4 * rat[r] / 128), 48'(gap));
        end
    endtask
    // enable low freezes the divider and refuses a config load
    task automatic t_freeze;
        int       gap;
        int       n;
        sti_cfg_t keep;
        keep = '{mode: STI_MODE_I2S, width: STI_WID_24, ratio: STI_RATIO_768};
        wait_tick(gap);
        ce     <= 1'b0;
        cfg    <= '{mode: STI_MODE_LJ, width: STI_WID_16, ratio: STI_RATIO_256};
        cfg_wr <= 1'b1;
        n = 0;
        repeat (40) begin
            @(posedge clk);
            if (tick !== 1'b0) n++;
        end
        check("frozen ticks", 48'h0, 48'(n));
        cfg_wr <= 1'b0;
        ce     <= 1'b1;
        @(posedge clk);
        check("frozen cfg", 48'(keep), 48'(cfg_o));
        repeat (2) wait_tick(gap);
        check("thawed tick gap", 48'(4 * 768 / 128), 48'(gap));
    endtask

    task automatic summarize;
        if (bad_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        arst_n    = 1'b0;
        cfg_wr    = 1'b0;
        ce        = 1'b1;
        cfg       = STI_CFG_RST;
        osc_cnt   = 2'h0;
        osc       = 1'b0;
        cyc       = 0;
        n_pairs   = 0;
        bad_count = 0;
        n_tests   = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_default();
        t_i2s();
        t_lj();
        t_rj();
        t_reset();
        t_divider();
        t_freeze();
        summarize();
    end
endmodule

// ==== tb/sti_src_model.sv ====
// serial audio source model driving bit clock, frame sync and data
module sti_src_model
    import sti_pkg::*;
(
    input  wire logic i_clk,  // system clock
    output logic      o_bclk, // bit clock
    output logic      o_fs,   // frame sync
    output logic      o_sd    // serial data
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // bit and frame drivers
    // ======================================================================
    initial begin
        o_bclk = 1'b1;
        o_fs   = 1'b1;
        o_sd   = 1'b0;
    end
    // changes land in the low phase, so the rise sees settled lines
    task automatic put_bit(input logic fs, input logic d);
        @(posedge i_clk);
        o_bclk <= 1'b0;
        o_fs   <= fs;
        o_sd   <= d;
        repeat (2) @(posedge i_clk);
        o_bclk <= 1'b1;
        @(posedge i_clk);
    endtask
    // unused slots toggle so stale bits never pass for data
    function automatic logic slot(input logic [1:0] m, input int w,
                                  input logic [23:0] s, input int k);
        int i;
        i = (m == STI_MODE_LJ) ? w - 1 - k :
            (m == STI_MODE_RJ) ? 31 - k : w - k;
        return (i >= 0 && i < w) ? s[i] : k[0];
    endfunction
    task automatic send_frame(input logic [1:0] m, input int w,
                              input logic [23:0] l, input logic [23:0] r);
        logic lft;
        lft = (m == STI_MODE_LJ) || (m == STI_MODE_RJ);
        for (int k = 0; k < 64; k++) begin
            put_bit((k < 32) ? lft : !lft, slot(m, w, (k < 32) ? l : r, k % 32));
        end
        o_sd <= !o_sd;
    endtask
endmodule
